// file: hdl/cas_pkg.sv
// Purpose: shared constants for the command source arbiter
// Assumes: selections are 16-bit values, operation mode is a 3-bit code
// Notes: operation mode codes are fixed by the mode switching logic
package cas_pkg;

    // ------------------------------------------------------------
    // operation mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_LOCAL = 3'h0; // local operation mode
    localparam logic [2:0] MODE_EXT = 3'h1; // external terminals
    localparam logic [2:0] MODE_COMB1 = 3'h2; // combined mode 1
    localparam logic [2:0] MODE_COMB2 = 3'h3; // combined mode 2
    localparam logic [2:0] MODE_NET = 3'h4; // network mode

    // ------------------------------------------------------------
    // selection values
    // ------------------------------------------------------------
    localparam logic [15:0] SRC_COMM = 16'h0000; // communication source
    localparam logic [15:0] SRC_EXT = 16'h0001; // external source
    localparam logic [15:0] FREQ_EXT_COMM = 16'h0002; // ext, comm kept
    localparam logic [15:0] LOCAL_CONN = 16'h0002; // front connector
    localparam logic [15:0] LOCAL_PANEL = 16'h0004; // operation panel
    localparam logic [15:0] LOCAL_AUTO = 16'h270f; // unit auto detect

    // ------------------------------------------------------------
    // reset values of the selections
    // ------------------------------------------------------------
    localparam logic [15:0] START_SEL_RST = 16'h0000;
    localparam logic [15:0] FREQ_SEL_RST = 16'h0000;
    localparam logic [15:0] LOCAL_SEL_RST = 16'h270f;

    // ------------------------------------------------------------
    // selection index on the parameter port
    // ------------------------------------------------------------
    localparam logic [1:0] PSEL_START = 2'h0; // start_source_select
    localparam logic [1:0] PSEL_FREQ = 2'h1; // frequency_source_select
    localparam logic [1:0] PSEL_LOCAL = 2'h2; // local_mode_source_select

    // write_protect_select value that opens every parameter
    localparam logic [1:0] WP_ALL = 2'h2;

    // pin synchroniser lane positions
    localparam int PIN_W = 5;
    localparam int PIN_UNIT = 0;
    localparam int PIN_START = 1;
    localparam int PIN_STOP = 2;
    localparam int PIN_T4SEL = 3;
    localparam int PIN_MSPEED = 4;

    // who commands the drive in local operation mode
    typedef enum logic [1:0] {
        LOC_PANEL,
        LOC_UNIT,
        LOC_CONN
    } cas_local_t;

endpackage

// file: hdl/cas_sync.sv
// Purpose: two flip-flop synchroniser for a group of pins
// Assumes: every lane is an independent level
// Notes: first stage feeds only the second stage
module cas_sync #(
    parameter int W = 1
) (
    input wire logic REF_CLK, // system clock
    input wire logic RST_B, // synchronous reset, active low
    input wire logic [W-1:0] din, // asynchronous levels
    output logic [W-1:0] dout // synchronised levels
);
    logic [W-1:0] meta_r;

    // ------------------------------------------------------------
    // two stage capture
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

// file: hdl/cas_sel_latch.sv
// Purpose: one source selection, stored value and value in force
// Assumes: load pulse comes from an accepted drive reset
// Notes: a write changes only the stored value until the next load
module cas_sel_latch #(
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input wire logic REF_CLK, // system clock
    input wire logic RST_B, // power-on reset, active low
    input wire logic wr, // write strobe
    input wire logic [15:0] wr_data, // value written
    input wire logic load, // adopt stored value
    output logic [15:0] stored_r, // value last written
    output logic [15:0] active_r // value in force
);
    // ------------------------------------------------------------
    // stored copy
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            stored_r <= RST_VAL;
        end else if (wr) begin
            stored_r <= wr_data;
        end
    end

    // value in force changes only at power-on or drive reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            active_r <= RST_VAL;
        end else if (load) begin
            active_r <= stored_r;
        end
    end
endmodule

// file: hdl/cas_arbiter.sv
// Purpose: decides which party may start, stop, set frequency, write
//          parameters and reset the drive
// Assumes: mode, error and request pulses come from same-clock logic
// Notes: every grant appears one cycle after its request
//
// What this block does
// - start selection 0 is communication, 1 is terminals.
// - frequency selection 0 comm, 1 external, 2 external plus comm.
// - local selection 2 gives connector, 4 gives panel.
// - at 9999 panel commands unless a parameter unit is attached.
// - at 9999 connector traffic never takes the local source.
// - local selection 2 refuses switching into network mode.
// - written selections act only after power-on or drive reset.
// - mode lamps go dark when the panel is not source.
// - reads and monitoring are always accepted.
// - at local selection 2, external or combined 1 connector stop acts as local stop.
// - else connector commands only in network mode, per selections.
// - after a communication error host drive reset is rejected.
// - terminals start and stop in external, combined 1, and network mode at start selection 1.
// - combined 1 frequency: multi-speed, terminal 4 when selected.
// - write refused means clear refused; any-mode params writable.
module cas_arbiter
    import cas_pkg::*;
(
    input wire logic REF_CLK, // 25 MHz clock
    input wire logic RST_B, // power-on reset, active low
    input wire logic [2:0] OP_MODE, // current operation mode
    input wire logic COMM_ERROR, // rs-485 error seen, level
    input wire logic [1:0] WRITE_PROTECT_SEL, // write_protect_select
    input wire logic UNIT_PRESENT, // parameter unit attached pin
    input wire logic PARAM_WR_STB, // selection write strobe
    input wire logic [1:0] PARAM_WR_SEL, // which selection
    input wire logic [15:0] PARAM_WR_DATA, // value to write
    input wire logic [1:0] PARAM_RD_SEL, // selection to read back
    input wire logic CONN_START, // connector start request
    input wire logic CONN_STOP, // connector stop request
    input wire logic CONN_FREQ, // connector frequency request
    input wire logic CONN_PWRITE, // connector parameter write
    input wire logic CONN_ANY_MODE, // that parameter is any-mode
    input wire logic CONN_PCLEAR, // connector parameter clear
    input wire logic CONN_RESET, // connector drive reset request
    input wire logic CONN_READ, // connector read or monitor
    input wire logic PANEL_RESET, // panel or unit drive reset
    input wire logic TERM_RESET, // terminal drive reset pulse
    input wire logic NET_SWITCH_REQ, // request to enter network mode
    input wire logic TERM_START, // terminal start pin
    input wire logic TERM_STOP, // terminal stop pin
    input wire logic TERMINAL4_INPUT_SELECT, // terminal 4 select pin
    input wire logic TERM_MULTISPEED, // multi-speed pin active
    output logic CONN_START_OK, // connector start granted
    output logic CONN_STOP_OK, // connector stop granted
    output logic LOCAL_STOP_INDICATION, // local stop shown
    output logic CONN_FREQ_OK, // connector frequency granted
    output logic CONN_PWRITE_OK, // connector write granted
    output logic CONN_PCLEAR_OK, // connector clear granted
    output logic CONN_RESET_OK, // connector reset granted
    output logic CONN_READ_OK, // read or monitor granted
    output logic CONN_REJECT, // any connector request refused
    output logic NET_SWITCH_OK, // network switch granted
    output logic NET_SWITCH_REJ, // network switch refused
    output logic DRIVE_RESET, // drive reset taken, pulse
    output logic TERM_RUN, // terminal run command in force
    output logic TERM_T2_OK, // terminal 2 frequency valid
    output logic TERM_T4_OK, // terminal 4 frequency valid
    output logic TERM_MSPEED_OK, // multi-speed setting valid
    output logic [1:0] LOCAL_SOURCE, // local source code
    output logic LAMP_LOCAL, // local mode lamp
    output logic LAMP_EXT, // external mode lamp
    output logic LAMP_NET, // network mode lamp
    output logic [15:0] PARAM_RD_DATA // read back selection
);
    // ----------
    // declarations
    // ----------
    logic [PIN_W-1:0] pins_s;
    logic [15:0] start_st, start_act;
    logic [15:0] freq_st, freq_act;
    logic [15:0] local_st, local_act;
    logic load_sel;
    logic unit_s, tstart_s, tstop_s, t4sel_s, mspeed_s;
    logic m_local, m_ext, m_comb1, m_comb2, m_net;
    logic conn_owner;
    cas_local_t loc_src;
    logic start_ok, stop_ok, pstop, freq_ok, pwr_ok, pclr_ok;
    logic rst_ok, reset_any, net_ok;
    logic run_ok, t2_ok, t4_ok, ms_ok;
    logic reject;
    logic term_run_r, term_run_nxt;

    // ----------
    // pin synchronisers
    // ----------
    cas_sync #(
        .W(PIN_W)
    ) u_sync (
        .REF_CLK(REF_CLK),
        .RST_B(RST_B),
        .din({TERM_MULTISPEED, TERMINAL4_INPUT_SELECT, TERM_STOP,
              TERM_START, UNIT_PRESENT}),
        .dout(pins_s)
    );

    assign unit_s = pins_s[PIN_UNIT];
    assign tstart_s = pins_s[PIN_START];
    assign tstop_s = pins_s[PIN_STOP];
    assign t4sel_s = pins_s[PIN_T4SEL];
    assign mspeed_s = pins_s[PIN_MSPEED];

    // ----------
    // source selections, stored and in force
    // ----------
    // a taken drive reset adopts the stored values
    assign load_sel = reset_any;

    cas_sel_latch #(
        .RST_VAL(START_SEL_RST)
    ) u_start_sel (
        .REF_CLK(REF_CLK),
        .RST_B(RST_B),
        .wr(PARAM_WR_STB && PARAM_WR_SEL == PSEL_START),
        .wr_data(PARAM_WR_DATA),
        .load(load_sel),
        .stored_r(start_st),
        .active_r(start_act)
    );

    cas_sel_latch #(
        .RST_VAL(FREQ_SEL_RST)
    ) u_freq_sel (
        .REF_CLK(REF_CLK),
        .RST_B(RST_B),
        .wr(PARAM_WR_STB && PARAM_WR_SEL == PSEL_FREQ),
        .wr_data(PARAM_WR_DATA),
        .load(load_sel),
        .stored_r(freq_st),
        .active_r(freq_act)
    );

    cas_sel_latch #(
        .RST_VAL(LOCAL_SEL_RST)
    ) u_local_sel (
        .REF_CLK(REF_CLK),
        .RST_B(RST_B),
        .wr(PARAM_WR_STB && PARAM_WR_SEL == PSEL_LOCAL),
        .wr_data(PARAM_WR_DATA),
        .load(load_sel),
        .stored_r(local_st),
        .active_r(local_act)
    );

    // ----------
    // mode decode
    // ----------
    assign m_local = (OP_MODE == MODE_LOCAL);
    assign m_ext = (OP_MODE == MODE_EXT);
    assign m_comb1 = (OP_MODE == MODE_COMB1);
    assign m_comb2 = (OP_MODE == MODE_COMB2);
    assign m_net = (OP_MODE == MODE_NET);

    // connector owns local mode only on explicit selection
    assign conn_owner = (local_act == LOCAL_CONN);

    // ----------
    // local mode command source
    // ----------
    always_comb begin
        if (local_act == LOCAL_CONN) begin
            loc_src = LOC_CONN;
        end else if (local_act == LOCAL_PANEL) begin
            loc_src = LOC_PANEL;
        end else if (unit_s) begin
            loc_src = LOC_UNIT;
        end else begin
            loc_src = LOC_PANEL;
        end
    end

    // ----------
    // connector permissions, decided in the request cycle
    // ----------
    always_comb begin
        start_ok = 1'b0;
        stop_ok = 1'b0;
        pstop = 1'b0;
        freq_ok = 1'b0;
        pwr_ok = 1'b0;
        rst_ok = 1'b0;
        if (conn_owner) begin
            // host has set the connector as local source
            start_ok = m_local || m_comb2;
            stop_ok = m_local || m_comb2;
            pstop = m_ext || m_comb1;
            freq_ok = m_local || m_comb1;
            pwr_ok = m_local || m_comb1 || m_comb2;
            rst_ok = !m_net;
        end else if (m_net) begin
            // network mode, steered by the selections
            start_ok = (start_act == SRC_COMM);
            stop_ok = (start_act == SRC_COMM);
            freq_ok = (freq_act == SRC_COMM) ||
                      (freq_act == FREQ_EXT_COMM);
            pwr_ok = 1'b1;
            rst_ok = 1'b1;
        end
        // a communication error blocks host resets
        if (COMM_ERROR) begin
            rst_ok = 1'b0;
        end
        // any-mode parameters and open protection stay writable
        if (CONN_ANY_MODE || WRITE_PROTECT_SEL == WP_ALL) begin
            pwr_ok = 1'b1;
        end
    end

    // clear follows the mode and source rights, not the any-mode mark
    assign pclr_ok = (conn_owner && (m_local || m_comb1 || m_comb2)) ||
                     (!conn_owner && m_net);

    // network switch refused while connector owns local mode
    assign net_ok = !conn_owner;

    // drive reset from any accepted source
    assign reset_any = (CONN_RESET && rst_ok) || PANEL_RESET || TERM_RESET;

    // ----------
    // terminal permissions
    // ----------
    always_comb begin
        run_ok = 1'b0;
        t2_ok = 1'b0;
        t4_ok = 1'b0;
        ms_ok = 1'b0;
        if (m_ext) begin
            run_ok = 1'b1;
            t2_ok = 1'b1;
            t4_ok = 1'b1;
            ms_ok = 1'b1;
        end else if (m_comb1) begin
            run_ok = 1'b1;
            t4_ok = t4sel_s;
            ms_ok = 1'b1;
        end else if (m_comb2) begin
            t2_ok = 1'b1;
            t4_ok = 1'b1;
            ms_ok = 1'b1;
        end else if (m_net) begin
            run_ok = (start_act == SRC_EXT);
            t2_ok = (freq_act == SRC_EXT);
            t4_ok = (freq_act == SRC_EXT) ||
                    (freq_act == FREQ_EXT_COMM);
            ms_ok = (freq_act != SRC_COMM);
        end
    end

    // terminal run level: start sets, stop or lost authority clears
    always_comb begin
        term_run_nxt = term_run_r;
        if (!run_ok || tstop_s) begin
            term_run_nxt = 1'b0;
        end else if (tstart_s) begin
            term_run_nxt = 1'b1;
        end
    end

    // any connector request that was not granted
    assign reject = (CONN_START && !start_ok) ||
                    (CONN_STOP && !stop_ok && !pstop) ||
                    (CONN_FREQ && !freq_ok) ||
                    (CONN_PWRITE && !pwr_ok) ||
                    (CONN_PCLEAR && !pclr_ok) ||
                    (CONN_RESET && !rst_ok);

    // ----------
    // connector grant pulses
    // ----------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            CONN_START_OK <= 1'b0;
            CONN_STOP_OK <= 1'b0;
            CONN_FREQ_OK <= 1'b0;
            CONN_PWRITE_OK <= 1'b0;
            CONN_PCLEAR_OK <= 1'b0;
            CONN_RESET_OK <= 1'b0;
            CONN_READ_OK <= 1'b0;
            CONN_REJECT <= 1'b0;
        end else begin
            CONN_START_OK <= CONN_START && start_ok;
            CONN_STOP_OK <= CONN_STOP && (stop_ok || pstop);
            CONN_FREQ_OK <= CONN_FREQ && freq_ok;
            CONN_PWRITE_OK <= CONN_PWRITE && pwr_ok;
            CONN_PCLEAR_OK <= CONN_PCLEAR && pclr_ok;
            CONN_RESET_OK <= CONN_RESET && rst_ok;
            CONN_READ_OK <= CONN_READ;
            CONN_REJECT <= reject;
        end
    end

    // local stop display holds until the next drive reset
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            LOCAL_STOP_INDICATION <= 1'b0;
        end else if (CONN_STOP && pstop) begin
            LOCAL_STOP_INDICATION <= 1'b1;
        end else if (reset_any) begin
            LOCAL_STOP_INDICATION <= 1'b0;
        end
    end

    // ----------
    // mode switch answer and drive reset
    // ----------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            NET_SWITCH_OK <= 1'b0;
            NET_SWITCH_REJ <= 1'b0;
            DRIVE_RESET <= 1'b0;
        end else begin
            NET_SWITCH_OK <= NET_SWITCH_REQ && net_ok;
            NET_SWITCH_REJ <= NET_SWITCH_REQ && !net_ok;
            DRIVE_RESET <= reset_any;
        end
    end

    // ----------
    // terminal outputs
    // ----------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            term_run_r <= 1'b0;
        end else begin
            term_run_r <= term_run_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            TERM_RUN <= 1'b0;
            TERM_T2_OK <= 1'b0;
            TERM_T4_OK <= 1'b0;
            TERM_MSPEED_OK <= 1'b0;
        end else begin
            TERM_RUN <= term_run_nxt;
            TERM_T2_OK <= t2_ok;
            TERM_T4_OK <= t4_ok;
            TERM_MSPEED_OK <= ms_ok && mspeed_s;
        end
    end

    // ----------
    // source code and mode lamps
    // ----------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            LOCAL_SOURCE <= 2'h0;
            LAMP_LOCAL <= 1'b0;
            LAMP_EXT <= 1'b0;
            LAMP_NET <= 1'b0;
        end else begin
            LOCAL_SOURCE <= loc_src;
            if (loc_src == LOC_PANEL) begin
                LAMP_LOCAL <= m_local || m_comb1 || m_comb2;
                LAMP_EXT <= m_ext || m_comb1 || m_comb2;
                LAMP_NET <= m_net;
            end else begin
                LAMP_LOCAL <= 1'b0;
                LAMP_EXT <= 1'b0;
                LAMP_NET <= 1'b0;
            end
        end
    end

    // ----------
    // read back of stored selections
    // ----------
    always_ff @(posedge REF_CLK) begin
        if (!RST_B) begin
            PARAM_RD_DATA <= 16'h0000;
        end else begin
            unique case (PARAM_RD_SEL)
                PSEL_START: PARAM_RD_DATA <= start_st;
                PSEL_FREQ: PARAM_RD_DATA <= freq_st;
                PSEL_LOCAL: PARAM_RD_DATA <= local_st;
                default: PARAM_RD_DATA <= 16'h0000;
            endcase
        end
    end
endmodule

// file: tb/cas_arbiter_checker.sv
// Purpose: concurrent checks on the command source arbiter ports
// Assumes: one clock, synchronous active-low reset
// Notes: owner checks skip the cycle in which a drive reset lands
module cas_arbiter_checker
    import cas_pkg::*;
(
    input wire logic REF_CLK, RST_B, COMM_ERROR, DRIVE_RESET, TERM_RUN,
    input wire logic [2:0] OP_MODE,
    input wire logic [1:0] LOCAL_SOURCE,
    input wire logic CONN_START, CONN_STOP, CONN_RESET, CONN_READ,
    input wire logic NET_SWITCH_REQ, CONN_START_OK, CONN_STOP_OK,
    input wire logic CONN_RESET_OK, CONN_READ_OK, CONN_REJECT,
    input wire logic NET_SWITCH_REJ, LOCAL_STOP_INDICATION,
    input wire logic LAMP_LOCAL, LAMP_EXT, LAMP_NET
);
    timeunit 1ns;
    timeprecision 1ns;
    logic own, nown, ext1;
    // connector ownership, trusted only away from a drive reset
    assign own = LOCAL_SOURCE == 2'h2 && !DRIVE_RESET;
    assign nown = LOCAL_SOURCE != 2'h2 && !DRIVE_RESET;
    assign ext1 = OP_MODE == MODE_EXT || OP_MODE == MODE_COMB1;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    read_grant_a: assert property (CONN_READ |=> CONN_READ_OK)
        else $error("read request not granted");
    start_answer_a: assert property (
        CONN_START |=> CONN_START_OK || CONN_REJECT)
        else $error("start request left unanswered");
    error_reset_a: assert property (
        CONN_RESET && COMM_ERROR |=> !CONN_RESET_OK)
        else $error("reset granted after link error");
    lamps_dark_a: assert property (
        (LOCAL_SOURCE != 2'h0) [*2]
        |-> !(LAMP_LOCAL || LAMP_EXT || LAMP_NET))
        else $error("lamp lit while panel is not source");
    net_refuse_a: assert property (
        NET_SWITCH_REQ && own |=> NET_SWITCH_REJ)
        else $error("network switch not refused");
    local_stop_a: assert property (
        CONN_STOP && own && ext1 |=> CONN_STOP_OK && LOCAL_STOP_INDICATION)
        else $error("connector stop not shown as local stop");
    no_owner_a: assert property (
        CONN_START && nown && OP_MODE != MODE_NET
        |=> CONN_REJECT && !CONN_START_OK)
        else $error("start granted without ownership");
    term_auth_a: assert property (
        OP_MODE == MODE_LOCAL || OP_MODE == MODE_COMB2 |=> !TERM_RUN)
        else $error("terminal run without authority");
    sel_hold_a: assert property (
        !DRIVE_RESET && $past(!DRIVE_RESET)
        |-> (LOCAL_SOURCE == 2'h2) == ($past(LOCAL_SOURCE) == 2'h2))
        else $error("selection changed without drive reset");
    // main scenarios reached
    cover property (CONN_STOP_OK && LOCAL_STOP_INDICATION);
    cover property (NET_SWITCH_REJ);
    cover property (TERM_RUN);
endmodule

bind cas_arbiter cas_arbiter_checker i_cas_arbiter_checker (.*);

// file: tb/cas_host_model.sv
// Purpose: host on the front connector issuing one request a cycle
// Assumes: caller is aligned just after a rising clock edge
// Notes: kinds 0-6 start,stop,freq,pwrite,pclear,reset,read; else idle
module cas_host_model
    import cas_pkg::*;
(
    input wire logic REF_CLK, // system clock
    output logic [6:0] REQ // request lines, msb is start
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // request launcher
    // ----------------------------------------------------------------
    initial REQ = 7'h00;
    // grants expected with owner setup or network mode; reads and any-mode writes always
    task automatic send(input int k);
        REQ <= k < 7 ? 7'h40 >> k : 7'h00;
        @(posedge REF_CLK);
    endtask
endmodule

// file: tb/cas_arbiter_test.sv
// Purpose: self-checking bench for the command source arbiter
// Assumes: grants one cycle after each request
// Notes: sweeps every selection set against every operation mode
module cas_arbiter_test import cas_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, err = 1'b0, any = 1'b0, unit = 1'b0;
    logic stb = 1'b0, net = 1'b0, prst = 1'b0, tst = 1'b0, tsp = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] wsel = 2'h0, rsel = 2'h0, lsrc;
    logic [15:0] wdat = 16'h0000, rdat;
    logic [6:0] req;
    wire [6:0] ok;
    wire [2:0] lmp;
    logic rej, nok, nrej, run, t2, t4;
    logic [9:0] q[$];
    int n_fail = 0, compares = 0;
    cas_host_model i_cas_host_model (.REF_CLK(clk), .REQ(req));
    cas_arbiter i_cas_arbiter (.REF_CLK(clk), .RST_B(rst_b), .OP_MODE(mode),
        .COMM_ERROR(err), .WRITE_PROTECT_SEL({any, 1'b0}), .UNIT_PRESENT(unit),
        .PARAM_WR_STB(stb), .PARAM_WR_SEL(wsel), .PARAM_WR_DATA(wdat),
        .PARAM_RD_SEL(rsel), .CONN_START(req[6]), .CONN_STOP(req[5]),
        .CONN_FREQ(req[4]), .CONN_PWRITE(req[3]), .CONN_ANY_MODE(any),
        .CONN_PCLEAR(req[2]), .CONN_RESET(req[1]), .CONN_READ(req[0]),
        .PANEL_RESET(prst), .TERM_RESET(1'b0), .NET_SWITCH_REQ(net),
        .TERM_START(tst), .TERM_STOP(tsp), .TERMINAL4_INPUT_SELECT(1'b0),
        .TERM_MULTISPEED(1'b0), .CONN_START_OK(ok[6]), .CONN_STOP_OK(ok[5]),
        .LOCAL_STOP_INDICATION(), .CONN_FREQ_OK(ok[4]),
        .CONN_PWRITE_OK(ok[3]), .CONN_PCLEAR_OK(ok[2]),
        .CONN_RESET_OK(ok[1]), .CONN_READ_OK(ok[0]), .CONN_REJECT(rej),
        .NET_SWITCH_OK(nok), .NET_SWITCH_REJ(nrej), .DRIVE_RESET(),
        .TERM_RUN(run), .TERM_T2_OK(t2), .TERM_T4_OK(t4), .TERM_MSPEED_OK(),
        .LOCAL_SOURCE(lsrc), .LAMP_LOCAL(lmp[2]), .LAMP_EXT(lmp[1]),
        .LAMP_NET(lmp[0]), .PARAM_RD_DATA(rdat));
    // ----------------------------------------------------------------
    // clock, compare and verdict
    // ----------------------------------------------------------------
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // grant vector {ok, reject, net ok, net refuse} for one request kind
    function automatic logic [9:0] want(int k, logic [15:0] ls, ss, fs,
                                        logic e, a);
        logic o, mx, n, st, sp, fq, cl, rs;
        logic [6:0] g;
        o = ls == LOCAL_CONN;
        mx = mode == MODE_EXT || mode == MODE_COMB1;
        n = mode == MODE_NET;
        st = o ? mode == MODE_LOCAL || mode == MODE_COMB2 : n && ss == SRC_COMM;
        sp = st || (o && mx);
        fq = o ? mode == MODE_LOCAL || mode == MODE_COMB1 : n && fs != SRC_EXT;
        cl = o ? !(mode == MODE_EXT || n) : n;
        rs = (o ? !n : n) && !e;
        g = {st, sp, fq, cl || a, cl, rs, 1'b1};
        if (k == 7) return o ? 10'h001 : 10'h002;
        return g[6 - k] ? 10'h200 >> k : 10'h004;
    endfunction
    // one request; kind 7 asks for network mode, kind 8 idles
    task automatic go(int k, logic [15:0] ls, ss, fs);
        logic e, a;
        e = 1'($urandom % 2);
        a = 1'($urandom % 2);
        err <= e;
        any <= a;
        net <= k == 7;
        if (k < 8) q.push_back(want(k, ls, ss, fs, e, a));
        i_cas_host_model.send(k);
    endtask
    task automatic rd(logic [1:0] s, logic [15:0] e);
        rsel <= s;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(rdat, e);
        @(posedge clk);
    endtask
    // three selections written back to back
    task automatic setsel(logic [15:0] ls, ss, fs);
        stb <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            wsel <= 2'(s);
            wdat <= s == 0 ? ss : s == 1 ? fs : ls;
            @(posedge clk);
        end
        stb <= 1'b0;
    endtask
    // results taken off the queue as they appear
    always @(negedge clk) begin
        if (|{ok, rej, nok, nrej}) chk({ok, rej, nok, nrej},
                                       q.size() ? q.pop_front() : 10'h3ff);
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] ls, ss, fs, pl;
        logic [1:0] es;
        void'($urandom(19));
        pl = LOCAL_AUTO;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(PSEL_START, START_SEL_RST);
        rd(PSEL_FREQ, FREQ_SEL_RST);
        rd(PSEL_LOCAL, LOCAL_SEL_RST);
        $display("reset values done");
        for (int c = 0; c < 18; c++) begin
            ls = c < 6 ? LOCAL_AUTO : c < 12 ? LOCAL_PANEL : LOCAL_CONN;
            ss = 16'(c % 2);
            fs = 16'((c / 2) % 3);
            setsel(ls, ss, fs);
            go(7, pl, ss, fs);
            go(8, pl, ss, fs);
            rd(PSEL_LOCAL, ls);
            prst <= 1'b1;
            unit <= 1'($urandom % 2);
            @(posedge clk);
            prst <= 1'b0;
            repeat (5) @(posedge clk);
            for (int m = 0; m < 5; m++) begin
                mode <= 3'(m);
                @(posedge clk);
                for (int k = 0; k < 9; k++) go(k, ls, ss, fs);
                tst <= 1'b1;
                @(posedge clk);
                tst <= 1'b0;
                repeat (4) @(posedge clk);
                @(negedge clk);
                chk(run, m == 1 || m == 2 ||
                    (m == 4 && ss == SRC_EXT));
                chk({t2, t4}, {m == 1 || m == 3 || (m == 4 && fs == SRC_EXT),
                    m == 1 || m == 3 || (m == 4 && fs != SRC_COMM)});
                @(posedge clk);
                tsp <= 1'b1;
                repeat (4) @(posedge clk);
                tsp <= 1'b0;
                @(posedge clk);
            end
            @(negedge clk);
            es = ls == LOCAL_CONN ? 2'h2 : ls == LOCAL_AUTO && unit ? 2'h1 : 2'h0;
            chk(lsrc, es);
            chk(lmp, |es ? 3'h0 : 3'h1);
            @(posedge clk);
            pl = ls;
            $display("config %0d done", c);
        end
        chk(16'(q.size()), 16'h0000);
        print_verdict();
    end
endmodule
